// ---- rtl/ptm_timer.sv ----
// Periodic 10-bit timer with compare A/P, PWM, single pulse and counter modes
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1 - 10-bit up-counter, internal or external clock
// R2 - Two 10-bit comparators A and P
// R3 - Counter read-only; cleared on switch-on
// R4 - Overflow or selected match clears, raises flag; with A clear select, overflow clears without a flag
// R5 - Pause holds counter, resumes from value
// R6 - Three-bit clock select decodes eight sources; CK_SUB0 and CK_SUB1 give the same sub-clock tick
// R7 - Switch-off stops, keeps count; on clears
// R8 - Switch-on resets output to initial level
// R9 - Two-bit mode field selects operating mode
// R10 - Software switches off before mode change
// R11 - Timer mode: output unused, bits ignored
// R12 - Compare mode: A match none/low/high/toggle
// R13 - PWM modes: inactive, active, PWM, pulse
// R14 - Requested level equal initial gives nothing
// R15 - Software changes pin function only off
// R16 - Initial-level bit sets level per mode
// R17 - Invert bit inverts output pin
// R18 - Software writes reserved bit as zero
// R19 - Clear select: A, else P or overflow
// R20 - Counter readable as low/high byte pair
// R21 - A-clear: only A flag, never P
// R22 - PWM: P sets period, A sets duty
// R23 - External input synchronised, edge counted
module ptm_timer
   import ptm_pkg::*;
(
   // Clock, reset, enable
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       clk_en,
   // Register port
   input  wire logic [2:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // Pins and events
   input  wire logic       external_count_input,
   output logic            timer_output_pin,
   output logic            match_a_flag,
   output logic            match_p_flag
);

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   logic [7:0] ctrl0_q;
   logic [7:0] ctrl1_q;
   logic [9:0] cmp_a_q;
   logic [9:0] cmp_p_q;
   logic [9:0] cnt_q;
   logic       on_prev_q;
   logic       out_q;
   logic       ext_s1_q;
   logic       ext_s2_q;
   logic       ext_s3_q;
   logic [5:0] pre_q;
   logic [11:0] sub_q;
   ptm_ctrl_s  ctl;

   assign ctl = '{counter_pause:         ctrl0_q[POS_PAUSE],
                  count_clock_select:    ptm_cksel_e'(ctrl0_q[POS_CKSEL +: 3]),
                  module_on_off:         ctrl0_q[POS_ON],
                  operating_mode_select: ptm_mode_e'(ctrl1_q[POS_MODE +: 2]),
                  pin_function_select:   ctrl1_q[POS_PINF +: 2],
                  output_initial_level:  ctrl1_q[POS_INIT],
                  output_invert:         ctrl1_q[POS_INV],
                  clear_source_select:   ctrl1_q[POS_CLRSEL]};

   function automatic logic is_wr(input logic [2:0] a, input logic [2:0] ofs);
      return reg_wr && (a == ofs);
   endfunction

   // Single-pulse end clears the on bit from inside the block
   logic on_rise;
   logic sp_mode;
   logic sp_end;
   logic tick;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ctrl0_q <= CTRL0_RESET;
      end else if (clk_en) begin
         if (is_wr(reg_addr, OFS_CTRL0)) begin
            ctrl0_q <= {reg_wdata[7:3], 3'h0};
         end else if (sp_end) begin
            ctrl0_q[POS_ON] <= 1'b0;
         end else if (sp_mode && !ctl.module_on_off && ext_edge_pulse()) begin
            ctrl0_q[POS_ON] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ctrl1_q <= CTRL1_RESET;
         cmp_a_q <= CMP_RESET;
         cmp_p_q <= CMP_RESET;
      end else if (clk_en) begin
         if (is_wr(reg_addr, OFS_CTRL1)) ctrl1_q <= reg_wdata;
         if (is_wr(reg_addr, OFS_CMPA_L)) cmp_a_q[7:0] <= reg_wdata;
         if (is_wr(reg_addr, OFS_CMPA_H)) cmp_a_q[9:8] <= reg_wdata[1:0];
         if (is_wr(reg_addr, OFS_CMPP_L)) cmp_p_q[7:0] <= reg_wdata;
         if (is_wr(reg_addr, OFS_CMPP_H)) cmp_p_q[9:8] <= reg_wdata[1:0];
      end
   end

   // ----------------------------------------------------------------------
   // Read port: data valid in the cycle after the strobe
   // ----------------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (clk_en) begin
         reg_rdata <= 8'h00;
         if (reg_rd) begin
            case (reg_addr)
               OFS_CTRL0:  reg_rdata <= ctrl0_q;
               OFS_CTRL1:  reg_rdata <= ctrl1_q;
               OFS_CNT_L:  reg_rdata <= cnt_q[7:0];              // R20
               OFS_CNT_H:  reg_rdata <= {6'h00, cnt_q[9:8]};     // R20
               OFS_CMPA_L: reg_rdata <= cmp_a_q[7:0];
               OFS_CMPA_H: reg_rdata <= {6'h00, cmp_a_q[9:8]};
               OFS_CMPP_L: reg_rdata <= cmp_p_q[7:0];
               OFS_CMPP_H: reg_rdata <= {6'h00, cmp_p_q[9:8]};
               default:    reg_rdata <= 8'h00;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // External input synchroniser and count tick
   // ----------------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         ext_s3_q <= 1'b0;
      end else if (clk_en) begin
         ext_s1_q <= external_count_input;  // R23
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
      end
   end

   // Edge of the selected polarity; falling used unless rising selected
   function automatic logic ext_edge_pulse();
      return (ctl.count_clock_select == CK_EXTR) ? (ext_s2_q && !ext_s3_q)
                                                 : (!ext_s2_q && ext_s3_q);
   endfunction

   // Prescalers free-run so the internal rates stay fixed
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pre_q <= 6'h00;
         sub_q <= 12'h000;
      end else if (clk_en) begin
         pre_q <= pre_q + 6'h01;
         sub_q <= (sub_q == 12'(SUB_DIV - 1)) ? 12'h000 : sub_q + 12'h001;
      end
   end

   always_comb begin
      case (ctl.count_clock_select)  // R6
         CK_SYS4: tick = (pre_q[1:0] == DIV_SYS4[1:0]);
         CK_SYS:  tick = 1'b1;
         CK_H16:  tick = (pre_q[3:0] == DIV_H16[3:0]);
         CK_H64:  tick = (pre_q == DIV_H64);
         CK_SUB0: tick = (sub_q == 12'h000);
         CK_SUB1: tick = (sub_q == 12'h000);
         CK_EXTR: tick = ext_edge_pulse();  // R23
         CK_EXTF: tick = ext_edge_pulse();  // R23
         default: tick = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------------
   // Counter, comparators and flags
   // ----------------------------------------------------------------------
   logic run;
   logic pwm_mode;
   logic hit_a;
   logic hit_p;
   logic ovf;
   logic clr_cnt;

   assign on_rise  = ctl.module_on_off && !on_prev_q;
   assign pwm_mode = (ctl.operating_mode_select == MODE_PWM);                  // R9
   assign sp_mode  = pwm_mode && (ctl.pin_function_select == 2'b11);
   // The switch-on edge only clears, so a stale count can never match there
   assign run      = ctl.module_on_off && !on_rise && !ctl.counter_pause && tick; // R5 R7
   assign hit_a    = run && (cnt_q == cmp_a_q);                               // R2
   assign hit_p    = run && (cnt_q == cmp_p_q) && (cmp_p_q != 10'h000);       // R2
   assign ovf      = run && (cnt_q == CNT_MAX);

   // Compare A flag is not raised when A is zero (overflow then rules)
   logic a_ev;
   logic p_ev;
   assign a_ev = hit_a && (cmp_a_q != 10'h000);
   assign sp_end = sp_mode && a_ev;

   always_comb begin
      if (pwm_mode) begin
         // PWM: P period, zero P means full 1024 span; single pulse ignores P
         clr_cnt = sp_mode ? 1'b0 : (hit_p || (cmp_p_q == 10'h000 && ovf));  // R22
         p_ev    = sp_mode ? 1'b0 : (hit_p || (cmp_p_q == 10'h000 && ovf));  // R4
      end else if (ctl.clear_source_select) begin
         clr_cnt = a_ev || ovf;                                               // R19 R4
         p_ev    = 1'b0;                                                      // R21
      end else begin
         // Overflow occurs with P at zero, at CNT_MAX or below the count, and counts as the P event
         clr_cnt = hit_p || ovf;                                              // R19 R4
         p_ev    = hit_p || ovf;                                              // R4
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cnt_q     <= 10'h000;
         on_prev_q <= 1'b0;
      end else if (clk_en) begin
         on_prev_q <= ctl.module_on_off;
         if (on_rise) begin
            cnt_q <= 10'h000;                                                 // R3 R7
         end else if (run && !sp_end) begin
            cnt_q <= clr_cnt ? 10'h000 : cnt_q + 10'h001;                     // R1 R4
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         match_a_flag <= 1'b0;
         match_p_flag <= 1'b0;
      end else if (clk_en) begin
         match_a_flag <= a_ev;                                                // R4
         match_p_flag <= p_ev;                                                // R4 R21
      end
   end

   // ----------------------------------------------------------------------
   // Output stage
   // ----------------------------------------------------------------------
   logic pwm_active;
   logic raw_out;
   // Duty above the period gives a fully active waveform
   assign pwm_active = (cnt_q < cmp_a_q);                                     // R22

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         out_q <= 1'b0;
      end else if (clk_en) begin
         if (on_rise) begin
            out_q <= ctl.output_initial_level;                                // R8 R16
         end else if (ctl.operating_mode_select == MODE_CMP && a_ev) begin
            case (ctl.pin_function_select)                                    // R12 R14
               2'b00:   out_q <= out_q;
               2'b01:   out_q <= 1'b0;
               2'b10:   out_q <= 1'b1;
               2'b11:   out_q <= !out_q;
               default: out_q <= out_q;
            endcase
         end else if (sp_end) begin
            out_q <= !ctl.output_initial_level;                               // R16
         end
      end
   end

   always_comb begin
      case (ctl.operating_mode_select)
         MODE_CMP: raw_out = out_q;
         MODE_PWM: begin
            case (ctl.pin_function_select)                                    // R13
               2'b00:   raw_out = !ctl.output_initial_level;
               2'b01:   raw_out = ctl.output_initial_level;
               2'b10:   raw_out = pwm_active ? ctl.output_initial_level   // R16
                                             : !ctl.output_initial_level;
               2'b11:   raw_out = ctl.module_on_off ? out_q : !ctl.output_initial_level;
               default: raw_out = 1'b0;
            endcase
         end
         default: raw_out = 1'b0;                                             // R11
      endcase
   end

   // Timer mode leaves the pin low; invert is ignored there
   assign timer_output_pin = (ctl.operating_mode_select == MODE_TMR) ? 1'b0
                             : (raw_out ^ ctl.output_invert);                 // R17 R11

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   a_on_clears_cnt: assert property (@(posedge clock) disable iff (!rst_n)   // R3
      clk_en && on_rise |=> cnt_q == 10'h000)
      else $error("counter not cleared on switch-on");
   a_pause_holds: assert property (@(posedge clock) disable iff (!rst_n)     // R5
      clk_en && ctl.counter_pause && !on_rise |=> $stable(cnt_q))
      else $error("counter moved while paused");
   a_off_holds: assert property (@(posedge clock) disable iff (!rst_n)       // R7
      clk_en && !ctl.module_on_off && !on_prev_q |=> $stable(cnt_q))
      else $error("counter moved while off");
   a_no_p_flag: assert property (@(posedge clock) disable iff (!rst_n)       // R21
      clk_en && !pwm_mode && ctl.clear_source_select |=> !match_p_flag)
      else $error("P flag with A clear select");
   a_a_clear: assert property (@(posedge clock) disable iff (!rst_n)         // R19
      clk_en && !pwm_mode && ctl.clear_source_select && a_ev && !on_rise
      |=> cnt_q == 10'h000)
      else $error("A match did not clear counter");
   a_init_level: assert property (@(posedge clock) disable iff (!rst_n)      // R8
      clk_en && on_rise |=> out_q == $past(ctl.output_initial_level))
      else $error("output not at initial level");
   a_invert_pin: assert property (@(posedge clock) disable iff (!rst_n)      // R17
      pwm_mode && ctl.pin_function_select == 2'b01
      |-> timer_output_pin == (ctl.output_initial_level ^ ctl.output_invert))
      else $error("polarity wrong");
   a_cnt_step: assert property (@(posedge clock) disable iff (!rst_n)        // R1
      clk_en && run && !clr_cnt && !on_rise && !sp_end
      |=> cnt_q == $past(cnt_q) + 10'h001)
      else $error("counter did not step");
   a_cmp_set: assert property (@(posedge clock) disable iff (!rst_n)         // R12
      clk_en && ctl.operating_mode_select == MODE_CMP && a_ev && !on_rise
      && ctl.pin_function_select == 2'b10 |=> out_q)
      else $error("compare set failed");
   a_p_overflow: assert property (@(posedge clock) disable iff (!rst_n)      // R4
      clk_en && !pwm_mode && !ctl.clear_source_select && ovf && cmp_p_q == 10'h000
      |=> match_p_flag)
      else $error("overflow raised no P flag");
   a_a_zero_quiet: assert property (@(posedge clock) disable iff (!rst_n)    // R4
      clk_en && cmp_a_q == 10'h000 |=> !match_a_flag)
      else $error("A flag with zero A value");
   a_p_clear: assert property (@(posedge clock) disable iff (!rst_n)         // R19 R22
      clk_en && !sp_mode && (pwm_mode || !ctl.clear_source_select) && hit_p && !on_rise
      |=> cnt_q == 10'h000)
      else $error("P match did not clear counter");
   a_read_idle: assert property (@(posedge clock) disable iff (!rst_n)       // R20
      clk_en && !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside its cycle");

   // Single pulse: the A match ends the pulse and switches the module off
   sequence s_pulse_end;
      clk_en && sp_end && !on_rise && !(reg_wr && reg_addr == OFS_CTRL0);
   endsequence
   sequence s_pulse_idle;
      !ctl.module_on_off && out_q == !$past(ctl.output_initial_level);
   endsequence
   a_pulse_stop: assert property (@(posedge clock) disable iff (!rst_n)      // R13
      s_pulse_end |=> s_pulse_idle)
      else $error("single pulse did not stop");

endmodule
`default_nettype wire

// ---- inc/ptm_pkg.sv ----
// Periodic timer package: register map, field positions, modes and constants
package ptm_pkg;

   // ----------------------------------------------------------------------
   // Register offsets (byte-wide registers, index order)
   // ----------------------------------------------------------------------
   localparam logic [2:0] OFS_CTRL0 = 3'h0;
   localparam logic [2:0] OFS_CTRL1 = 3'h1;
   localparam logic [2:0] OFS_CNT_L = 3'h2;
   localparam logic [2:0] OFS_CNT_H = 3'h3;
   localparam logic [2:0] OFS_CMPA_L = 3'h4;
   localparam logic [2:0] OFS_CMPA_H = 3'h5;
   localparam logic [2:0] OFS_CMPP_L = 3'h6;
   localparam logic [2:0] OFS_CMPP_H = 3'h7;

   // ----------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------
   localparam int POS_PAUSE   = 7;
   localparam int POS_CKSEL   = 4;
   localparam int POS_ON      = 3;
   localparam int POS_MODE    = 6;
   localparam int POS_PINF    = 4;
   localparam int POS_INIT    = 3;
   localparam int POS_INV     = 2;
   localparam int POS_CLRSEL  = 0;

   localparam logic [7:0] CTRL0_RESET = 8'h00;
   localparam logic [7:0] CTRL1_RESET = 8'h00;
   localparam logic [9:0] CMP_RESET   = 10'h000;
   localparam logic [9:0] CNT_MAX     = 10'h3FF;

   // Internal clock prescale match values (period minus one); SUB_DIV is a period in system clock cycles
   localparam logic [5:0] DIV_SYS4  = 6'h03;
   localparam logic [5:0] DIV_H16   = 6'h0F;
   localparam logic [5:0] DIV_H64   = 6'h3F;
   localparam int         SUB_DIV   = 3052;

   // ----------------------------------------------------------------------
   // Enumerations
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_CMP   = 2'b00,
      MODE_UNDEF = 2'b01,
      MODE_PWM   = 2'b10,
      MODE_TMR   = 2'b11
   } ptm_mode_e;

   typedef enum logic [2:0] {
      CK_SYS4 = 3'b000,
      CK_SYS  = 3'b001,
      CK_H16  = 3'b010,
      CK_H64  = 3'b011,
      CK_SUB0 = 3'b100,
      CK_SUB1 = 3'b101,
      CK_EXTR = 3'b110,
      CK_EXTF = 3'b111
   } ptm_cksel_e;

   // Decoded control fields
   typedef struct packed {
      logic       counter_pause;
      ptm_cksel_e count_clock_select;
      logic       module_on_off;
      ptm_mode_e  operating_mode_select;
      logic [1:0] pin_function_select;
      logic       output_initial_level;
      logic       output_invert;
      logic       clear_source_select;
   } ptm_ctrl_s;

endpackage

// ---- verification/ptm_pin_model.sv ----
// Partner model: drives the external count pin and watches the timer output pin
`timescale 1ns/1ps
`default_nettype none
module ptm_pin_model (
   // Clock
   input  wire logic clock,
   // Pins
   input  wire logic timer_output_pin,
   output logic      external_count_input
);
   logic last_v;

   initial external_count_input = 1'b0;

   // ----------------------------------------------------------------------
   // Pin driver
   // ----------------------------------------------------------------------
   // Each level is held at least two cycles so the two-flop synchroniser never drops one
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge clock);
         external_count_input <= 1'b1;
         repeat (2) @(posedge clock);
         external_count_input <= 1'b0;
         repeat (2) @(posedge clock);
      end
   endtask

   // ----------------------------------------------------------------------
   // Output observer
   // ----------------------------------------------------------------------
   task automatic watch(input int cycles, output int hi, output int edges);
      hi = 0;
      edges = 0;
      last_v = timer_output_pin;
      repeat (cycles) begin
         @(posedge clock);
         if (timer_output_pin === 1'b1) hi++;
         if (timer_output_pin !== last_v) edges++;
         last_v = timer_output_pin;
      end
   endtask
endmodule
`default_nettype wire

// ---- verification/tb_ptm_timer.sv ----
// Self-checking bench for the periodic timer: registers, clocks, modes, pins
`timescale 1ns/1ps
`default_nettype none
module tb_ptm_timer
   import ptm_pkg::*;
;
   logic       clock, rst_n, reg_wr, reg_rd, ext_in, pin, flag_a, flag_p, sv, fv, ce;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, rv, r1;
   int         n_mismatch, checked, na, np, cyc, hi, ed, a0, p0;
   int         ck_t [7] = '{0, 2, 3, 4, 5, 6, 7};
   int         n_t  [7] = '{395, 1595, 6395, 6200, 6200, 5, 3};
   int         e_t  [7] = '{100, 100, 100, 2, 2, 5, 3};

   ptm_timer ptm_timer_i (.clock(clock), .rst_n(rst_n), .clk_en(ce), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .external_count_input(ext_in), .timer_output_pin(pin), .match_a_flag(flag_a),
      .match_p_flag(flag_p));
   ptm_pin_model ptm_pin_model_i (.clock(clock), .timer_output_pin(pin),
      .external_count_input(ext_in));

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // Flag tally and hang guard
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (flag_a === 1'b1) na <= na + 1;
      if (flag_p === 1'b1) np <= np + 1;
      if (cyc == 40000) begin
         n_mismatch++;
         stop_test();
      end
   end

   // ----------------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------------
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic rng(input string nm, input int lo, input int up, input int g);
      checked++;
      if (g < lo || g > up) begin
         n_mismatch++;
         $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, up, g);
      end
   endtask
   task automatic cfg(input logic [7:0] c1, input logic [9:0] a, input logic [9:0] p);
      wr(OFS_CTRL0, 8'h00);
      wr(OFS_CMPA_L, a[7:0]);
      wr(OFS_CMPA_H, {6'h00, a[9:8]});
      wr(OFS_CMPP_L, p[7:0]);
      wr(OFS_CMPP_H, {6'h00, p[9:8]});
      wr(OFS_CTRL1, c1);
   endtask
   task automatic win(input int n);
      a0 = na;
      p0 = np;
      ptm_pin_model_i.watch(n, hi, ed);
   endtask
   task automatic stop_test();
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------------
   initial begin
      {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      {n_mismatch, checked, na, np, cyc} = '0;
      ce = 1'b1;
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         rd(3'(i), rv);
         chk("reset value", 8'h00, rv);
      end
      wr(OFS_CTRL0, 8'hFF);
      rd(OFS_CTRL0, rv);
      chk("ctrl0 bits", 8'hF8, rv);
      wr(OFS_CTRL1, 8'hF9);
      rd(OFS_CTRL1, rv);
      chk("ctrl1 bits", 8'hF9, rv);
      for (int i = 4; i < 8; i++) begin
         wr(3'(i), 8'hFF);
         rd(3'(i), rv);
         chk("compare byte", i[0] ? 8'h03 : 8'hFF, rv);
      end
      wr(OFS_CNT_L, 8'h55);
      wr(OFS_CNT_H, 8'h55);
      rd(OFS_CNT_L, rv);
      chk("count low ro", 8'h00, rv);
      rd(OFS_CNT_H, rv);
      chk("count high ro", 8'h00, rv);
      $display("test registers done");

      cfg(8'h00, 10'h000, 10'h000);
      wr(OFS_CTRL0, 8'h18);
      repeat (300) @(posedge clock);
      wr(OFS_CTRL0, 8'h98);
      rd(OFS_CNT_H, rv);
      chk("count high", 8'h01, rv);
      rd(OFS_CNT_L, r1);
      rng("count low", 40, 55, r1);
      repeat (5) @(posedge clock);
      rd(OFS_CNT_L, rv);
      chk("paused count", r1, rv);
      wr(OFS_CTRL0, 8'h18);
      repeat (10) @(posedge clock);
      wr(OFS_CTRL0, 8'h10);
      rd(OFS_CNT_L, rv);
      rng("resumed count", r1 + 10, r1 + 14, rv);
      r1 = rv;
      repeat (5) @(posedge clock);
      rd(OFS_CNT_L, rv);
      chk("off count", r1, rv);
      wr(OFS_CTRL0, 8'h98);
      rd(OFS_CNT_L, rv);
      chk("switch-on count", 8'h00, rv);
      // Clock enable low must freeze the running counter
      wr(OFS_CTRL0, 8'h18);
      ce <= 1'b0;
      repeat (20) @(posedge clock);
      ce <= 1'b1;
      wr(OFS_CTRL0, 8'h98);
      rd(OFS_CNT_L, rv);
      chk("frozen count", 8'h02, rv);
      $display("test count done");

      for (int i = 0; i < 7; i++) begin
         wr(OFS_CTRL0, 8'h00);
         wr(OFS_CTRL0, {1'b0, 3'(ck_t[i]), 1'b1, 3'h0});
         if (ck_t[i] >= 6) ptm_pin_model_i.pulses(n_t[i]);
         else repeat (n_t[i]) @(posedge clock);
         repeat (4) @(posedge clock);
         wr(OFS_CTRL0, {1'b1, 3'(ck_t[i]), 1'b1, 3'h0});
         rd(OFS_CNT_L, rv);
         rng("clock source", e_t[i] - (ck_t[i] < 6), e_t[i] + (ck_t[i] < 6), rv);
      end
      $display("test clocks done");

      for (int i = 0; i < 16; i++) begin
         cfg({2'b00, i[3:2], i[1], i[0], 2'b01}, 10'h005, 10'h002);
         wr(OFS_CTRL0, 8'h18);
         repeat (2) @(posedge clock);
         sv = i[1] ^ i[0];
         fv = (i[3:2] == 2'd1) ? i[0] : (i[3:2] == 2'd2) ? ~i[0] : sv;
         chk("initial pin", {7'h00, sv}, {7'h00, pin});
         win(62);
         rng("pin edges", (i[3:2] == 3) ? 10 : int'(fv != sv), (i[3:2] == 3) ? 10 : 1, ed);
         if (i[3:2] != 3) rng("pin edges", int'(fv != sv), int'(fv != sv), ed);
         if (i[3:2] != 3) chk("pin level", {7'h00, fv}, {7'h00, pin});
         rng("flag a", 10, 10, na - a0);
         rng("flag p", 0, 0, np - p0);
      end
      $display("test compare done");

      cfg(8'h00, 10'h000, 10'h000);
      wr(OFS_CTRL0, 8'h18);
      win(2100);
      rng("overflow p", 2, 2, np - p0);
      rng("overflow a", 0, 0, na - a0);
      cfg(8'hED, 10'h005, 10'h002);
      wr(OFS_CTRL0, 8'h18);
      win(64);
      rng("timer pin", 0, 0, hi);
      rng("timer flag a", 10, 10, na - a0);
      rng("timer flag p", 0, 0, np - p0);
      $display("test overflow timer done");

      for (int i = 0; i < 3; i++) begin
         cfg({2'b10, 2'(i), 4'b1001}, 10'h005, 10'h014);
         wr(OFS_CTRL0, 8'h18);
         win(420);
         rng("pwm high", (i == 0) ? 0 : (i == 1) ? 420 : 90,
             (i == 0) ? 0 : (i == 1) ? 420 : 110, hi);
         rng("pwm period", 19, 20, np - p0);
      end
      $display("test pwm done");

      cfg(8'hB8, 10'h00A, 10'h000);
      wr(OFS_CTRL0, 8'h18);
      win(100);
      rng("pulse width", 9, 12, hi);
      rd(OFS_CTRL0, rv);
      chk("pulse on bit", 8'h10, rv);
      // An edge on the count pin restarts the pulse by itself
      ptm_pin_model_i.pulses(1);
      win(100);
      rng("pin trigger width", 9, 12, hi);
      $display("test pulse done");
      stop_test();
   end
endmodule
`default_nettype wire
